// file: dv/hpe_egress_buffer_monitor.sv
// port assertions for the egress stream buffer
`timescale 1ns/1ps
module hpe_egress_buffer_monitor #(
  parameter NSTR = 2,
  parameter AW = 13
) (
  // all ports brought in; in_data and host_port_source_tag_reg are not checked
  input wire sys_clk,
  input wire rstn,
  input wire [NSTR-1:0] in_valid,
  input wire [NSTR*32-1:0] in_data,
  input wire [NSTR-1:0] in_last,
  input wire [NSTR-1:0] in_ready,
  input wire [NSTR*8-1:0] host_port_source_tag_reg,
  input wire [AW:0] egress_start_threshold,
  input wire [NSTR-1:0] out_valid,
  input wire [NSTR*32-1:0] out_data,
  input wire [NSTR-1:0] out_last,
  input wire [NSTR*8-1:0] descriptor_source_tag,
  input wire [NSTR-1:0] out_ready
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  wire tk = in_valid[0] & in_ready[0];
  wire gv = out_valid[0] & out_ready[0];
  // lane 0 words and packet ends held but not yet sent
  reg [15:0] occ_reg;
  reg [15:0] pk_reg;
  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      occ_reg <= 16'h0;
      pk_reg <= 16'h0;
    end else begin
      occ_reg <= occ_reg + tk - gv;
      pk_reg <= pk_reg + (tk & in_last[0]) - (gv & out_last[0]);
    end
  end
  property p_hold0;
    out_valid[0] && !out_ready[0] |=>
      out_valid[0] && $stable(out_data[31:0]) && $stable(out_last[0]);
  endproperty
  a_hold0: assert property (p_hold0)
    else $error("lane 0 word not held");
  property p_hold1;
    out_valid[1] && !out_ready[1] |=> out_valid[1] && $stable(out_data[63:32]);
  endproperty
  a_hold1: assert property (p_hold1)
    else $error("lane 1 word not held");
  property p_tag0;
    out_valid[0] && !out_ready[0] |=> $stable(descriptor_source_tag[7:0]);
  endproperty
  a_tag0: assert property (p_tag0)
    else $error("lane 0 tag moved");
  property p_tag1;
    out_valid[1] && !out_ready[1] |=> $stable(descriptor_source_tag[15:8]);
  endproperty
  a_tag1: assert property (p_tag1)
    else $error("lane 1 tag moved");
  property p_occ;
    out_valid[0] |-> occ_reg != 16'h0;
  endproperty
  a_occ: assert property (p_occ)
    else $error("word sent that was never taken");
  property p_cap;
    occ_reg <= 16'h1610;
  endproperty
  a_cap: assert property (p_cap)
    else $error("more words held than the buffer fits");
  property p_rdy;
    !in_ready[0] |-> occ_reg >= 16'h1600;
  endproperty
  a_rdy: assert property (p_rdy)
    else $error("input refused before buffer full");
  property p_whole;
    &egress_start_threshold && $rose(out_valid[0]) |-> pk_reg != 16'h0;
  endproperty
  a_whole: assert property (p_whole)
    else $error("start without a whole packet");
  property p_rst;
    $rose(rstn) |-> !out_valid[0] [*4];
  endproperty
  a_rst: assert property (p_rst)
    else $error("output too soon after reset");
  c_end: cover property (gv && out_last[0]);
  c_full: cover property (in_valid[0] && !in_ready[0]);
  c_stall: cover property (out_valid[1] && !out_ready[1]);
endmodule

// file: dv/hpe_sink_model.sv
// stream sink: fast, random stalls or stopped
`timescale 1ns/1ps
module hpe_sink_model (
  input wire sys_clk,
  input wire rstn,
  input wire [1:0] mode,
  output logic [1:0] out_ready
);
  integer seed = 35;
  always @(negedge sys_clk or negedge rstn) begin
    if (!rstn)
      out_ready <= 2'h0;
    else if (mode == 2'h2)
      out_ready <= 2'h0;
    else if (mode == 2'h1)
      out_ready <= $random(seed);
    else
      out_ready <= 2'h3;
  end
endmodule

// file: dv/tb.sv
// self-checking bench for the egress stream buffer
`timescale 1ns/1ps
module tb;
  reg sys_clk = 1'b0;
  reg rstn = 1'b0;
  reg [1:0] in_valid = 2'h0, in_last = 2'h0, mode = 2'h0;
  reg [63:0] in_data = 64'h0;
  reg [15:0] tags = 16'hA55A;
  reg [13:0] thr = 14'h3FFF;
  wire [1:0] in_ready, out_valid, out_last, out_ready;
  wire [63:0] out_data;
  wire [15:0] otag;
  integer seed = 35, n_fail = 0, tests_run = 0, cyc = 0, n;
  logic [32:0] q0[$], q1[$];
  always #10 sys_clk = ~sys_clk;
  hpe_egress_buffer uut (.sys_clk(sys_clk), .rstn(rstn), .in_valid(in_valid),
    .in_data(in_data), .in_last(in_last), .in_ready(in_ready),
    .host_port_source_tag_reg(tags), .egress_start_threshold(thr),
    .out_valid(out_valid), .out_data(out_data), .out_last(out_last),
    .descriptor_source_tag(otag), .out_ready(out_ready));
  hpe_sink_model sink (.sys_clk(sys_clk), .rstn(rstn), .mode(mode), .out_ready(out_ready));
  task print_verdict;
    $display("fails %0d of %0d", n_fail, tests_run);
    if (n_fail == 0 && tests_run > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task chk(input logic [40:0] g, input logic [40:0] e);
    tests_run++;
    if (g !== e) begin
      n_fail++;
      $display("Error %0t got %h want %h", $time, g, e);
    end
  endtask
  // holds valid up after the taking edge so words go back to back
  task automatic push(input int l, input logic [31:0] d, input logic e);
    @(negedge sys_clk);
    in_valid[l] = 1'b1;
    in_data[l*32 +: 32] = d;
    in_last[l] = e;
    #5;
    while (in_ready[l] !== 1'b1) begin
      @(negedge sys_clk);
      #5;
    end
    @(posedge sys_clk);
    if (l) q1.push_back({e, d});
    else q0.push_back({e, d});
    #1;
  endtask
  task automatic idle(input int l);
    @(negedge sys_clk);
    in_valid[l] = 1'b0;
  endtask
  task automatic look(input int l, input logic v);
    repeat (20) @(negedge sys_clk);
    chk(out_valid[l], v);
  endtask
  task automatic traffic(input int l);
    integer k, j, m;
    for (k = 0; k < 20; k++) begin
      m = 1 + ($random(seed) & 7);
      for (j = 0; j < m; j++)
        push(l, $random(seed), j == m - 1);
    end
    idle(l);
  endtask
  task drain;
    n = 0;
    while (q0.size() + q1.size() > 0 && n < 20000) begin
      @(negedge sys_clk);
      n++;
    end
    chk(q0.size() + q1.size(), 0);
  endtask
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc > 40000) begin
      n_fail++;
      print_verdict;
    end else begin
      if (out_valid[0] && out_ready[0])
        chk({otag[7:0], out_last[0], out_data[31:0]}, {tags[7:0], q0.pop_front()});
      if (out_valid[1] && out_ready[1])
        chk({otag[15:8], out_last[1], out_data[63:32]}, {tags[15:8], q1.pop_front()});
    end
  end
  initial begin
    repeat (4) @(negedge sys_clk);
    rstn = 1'b1;
    mode = 2'h2;
    repeat (4) push(0, $random(seed), 1'b0);
    idle(0);
    look(0, 1'b0);
    push(0, $random(seed), 1'b1);
    idle(0);
    look(0, 1'b1);
    mode = 2'h0;
    drain;
    thr = 14'h3;
    mode = 2'h2;
    repeat (4) push(1, $random(seed), 1'b0);
    idle(1);
    look(1, 1'b0);
    push(1, $random(seed), 1'b0);
    idle(1);
    look(1, 1'b1);
    push(1, $random(seed), 1'b1);
    idle(1);
    mode = 2'h0;
    drain;
    tags = $random(seed);
    thr = $random(seed) & 14'h7;
    mode = 2'h1;
    fork
      traffic(0);
      traffic(1);
    join
    drain;
    mode = 2'h2;
    thr = 14'h3;
    n = 0;
    while (in_ready[0] === 1'b1 && n < 6000) begin
      push(0, n, n % 64 == 63);
      n++;
    end
    idle(0);
    chk(n, 22528 / 4 + 16);
    mode = 2'h1;
    drain;
    print_verdict;
  end
endmodule
bind hpe_egress_buffer hpe_egress_buffer_monitor #(.NSTR(NSTR), .AW(AW)) mon (
  .sys_clk(sys_clk), .rstn(rstn), .in_valid(in_valid), .in_data(in_data),
  .in_last(in_last), .in_ready(in_ready), .host_port_source_tag_reg(host_port_source_tag_reg),
  .egress_start_threshold(egress_start_threshold), .out_valid(out_valid),
  .out_data(out_data), .out_last(out_last), .descriptor_source_tag(descriptor_source_tag),
  .out_ready(out_ready));

// file: shared/hpe_consts.vh
// constants for the host-port egress stream buffer
`ifndef HPE_CONSTS_VH
`define HPE_CONSTS_VH
`define HPE_BUF_BYTES 22528
`define HPE_STAGE_WORDS 2
`define HPE_IN_FIFO_DEPTH 16
`define HPE_STREAMS_BASE 2
`define HPE_STREAMS_FIVE 4
`define HPE_DATA_W 32
`define HPE_TAG_W 8
`define HPE_ST_IDLE 1'b0
`define HPE_ST_SEND 1'b1
`endif

// file: verilog/hpe_egress_buffer.v
// host-port egress stream buffers, one per ethernet source port
//
// Overview of operation
// - All of this logic runs on the one subsystem clock.
// - The base switch has three ports: host port 0 and ethernet ports 1 and 2.
// - The five-port variant adds ethernet ports 3 and 4.
// - There are two identical egress streams, one per ethernet source port, toward port 0.
// - Each stream carries the frame as a mac would send it, but in stream words.
// - Each packet leaves with its source port's programmed tag for the descriptor.
// - Each stream owns a 22K-byte packet buffer.
// - Sending starts only with a whole packet held or threshold plus two words held.
// - A two-word double buffer sits ahead of each stream output.
// - The five-port variant has two more identical streams.
`timescale 1ns/1ps
`include "hpe_consts.vh"
module hpe_egress_buffer #(
  parameter FIVE_PORT = 0,
  parameter DATA_W = `HPE_DATA_W,
  parameter TAG_W = `HPE_TAG_W,
  parameter BUF_BYTES = `HPE_BUF_BYTES,
  parameter NSTR = FIVE_PORT ? `HPE_STREAMS_FIVE : `HPE_STREAMS_BASE,
  parameter DEPTH = BUF_BYTES / (DATA_W / 8),
  parameter AW = 13
) (
  // clock and reset
  input wire sys_clk,
  input wire rstn,
  // words from the switch fabric, one lane per source ethernet port
  input wire [NSTR-1:0] in_valid,
  input wire [NSTR*DATA_W-1:0] in_data,
  input wire [NSTR-1:0] in_last,
  output wire [NSTR-1:0] in_ready,
  // configuration
  input wire [NSTR*TAG_W-1:0] host_port_source_tag_reg,
  input wire [AW:0] egress_start_threshold,
  // egress streams toward the streaming switch
  output wire [NSTR-1:0] out_valid,
  output wire [NSTR*DATA_W-1:0] out_data,
  output wire [NSTR-1:0] out_last,
  output wire [NSTR*TAG_W-1:0] descriptor_source_tag,
  input wire [NSTR-1:0] out_ready
);
  // buffer pointer advance with wrap; depth need not be a power of two
  function [AW-1:0] ptr_inc;
    input [AW-1:0] p;
    begin
      ptr_inc = (p == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : p + 1'b1;
    end
  endfunction

  // stage depth as a sliceable constant so the sums below keep their widths
  localparam integer STAGE_I = `HPE_STAGE_WORDS;

  genvar s;
  generate
    for (s = 0; s < NSTR; s = s + 1) begin : g_stream
      reg [DATA_W:0] mem [0:DEPTH-1];
      reg [AW-1:0] wr_ptr_reg;
      reg [AW-1:0] rd_ptr_reg;
      reg [AW:0] held_reg;
      reg [AW:0] unfetched_reg;
      reg [AW:0] pkts_reg;
      reg state_reg;
      reg [TAG_W-1:0] tag_reg;
      reg [DATA_W:0] rd_q_reg;
      reg rd_vld_reg;
      reg [DATA_W:0] st0_reg;
      reg [DATA_W:0] st1_reg;
      reg [1:0] st_cnt_reg;
      reg [TAG_W-1:0] rd_tag_reg;
      reg [TAG_W-1:0] st0_tag_reg;
      reg [TAG_W-1:0] st1_tag_reg;
      wire f_valid;
      wire [DATA_W:0] f_data;
      wire f_ready;
      wire wr;
      wire pop;
      wire issue;
      wire [DATA_W:0] rd_word;
      wire start;
      wire [AW+1:0] thr2;

      hpe_fifo #(
        .WIDTH(DATA_W + 1),
        .DEPTH(`HPE_IN_FIFO_DEPTH),
        .AW(4)
      ) u_in_fifo (
        .sys_clk(sys_clk),
        .rstn(rstn),
        .in_valid(in_valid[s]),
        .in_data({in_last[s], in_data[s*DATA_W +: DATA_W]}),
        .in_ready(in_ready[s]),
        .out_valid(f_valid),
        .out_data(f_data),
        .out_ready(f_ready)
      );

      // back-pressure: the input fifo stops draining once the packet buffer is full; the fabric stalls when that fifo fills too
      assign f_ready = (held_reg != DEPTH[AW:0]);
      assign wr = f_valid & f_ready;
      assign pop = (st_cnt_reg != 2'd0) & out_ready[s];
      assign rd_word = mem[rd_ptr_reg];
      // keep at most two words in stage plus in flight
      assign issue = (state_reg == `HPE_ST_SEND) && (unfetched_reg != {(AW+1){1'b0}}) &&
                     ({1'b0, st_cnt_reg} + {2'b00, rd_vld_reg} < STAGE_I[2:0]);
      assign thr2 = {1'b0, egress_start_threshold} + STAGE_I[AW+1:0];
      assign start = (pkts_reg != {(AW+1){1'b0}}) ||
                     ({1'b0, unfetched_reg} >= thr2);

      assign out_valid[s] = (st_cnt_reg != 2'd0);
      assign out_data[s*DATA_W +: DATA_W] = st0_reg[DATA_W-1:0];
      assign out_last[s] = st0_reg[DATA_W];
      assign descriptor_source_tag[s*TAG_W +: TAG_W] = st0_tag_reg;

      always @(posedge sys_clk) begin
        if (wr) begin
          mem[wr_ptr_reg] <= f_data;
        end
      end

      always @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
          wr_ptr_reg <= {AW{1'b0}};
          rd_ptr_reg <= {AW{1'b0}};
          held_reg <= {(AW+1){1'b0}};
          unfetched_reg <= {(AW+1){1'b0}};
          pkts_reg <= {(AW+1){1'b0}};
          state_reg <= `HPE_ST_IDLE;
          tag_reg <= {TAG_W{1'b0}};
          rd_q_reg <= {(DATA_W+1){1'b0}};
          rd_vld_reg <= 1'b0;
          st0_reg <= {(DATA_W+1){1'b0}};
          st1_reg <= {(DATA_W+1){1'b0}};
          st_cnt_reg <= 2'd0;
          rd_tag_reg <= {TAG_W{1'b0}};
          st0_tag_reg <= {TAG_W{1'b0}};
          st1_tag_reg <= {TAG_W{1'b0}};
        end else begin
          if (wr) begin
            wr_ptr_reg <= ptr_inc(wr_ptr_reg);
          end
          if (issue) begin
            rd_ptr_reg <= ptr_inc(rd_ptr_reg);
          end
          // space counts as used until the word leaves the stream
          if (wr && !pop) begin
            held_reg <= held_reg + 1'b1;
          end else if (pop && !wr) begin
            held_reg <= held_reg - 1'b1;
          end
          if (wr && !issue) begin
            unfetched_reg <= unfetched_reg + 1'b1;
          end else if (issue && !wr) begin
            unfetched_reg <= unfetched_reg - 1'b1;
          end
          if ((wr && f_data[DATA_W]) && !(issue && rd_word[DATA_W])) begin
            pkts_reg <= pkts_reg + 1'b1;
          end else if (!(wr && f_data[DATA_W]) && (issue && rd_word[DATA_W])) begin
            pkts_reg <= pkts_reg - 1'b1;
          end
          case (state_reg)
            `HPE_ST_IDLE: begin
              if (start) begin
                state_reg <= `HPE_ST_SEND;
                tag_reg <= host_port_source_tag_reg[s*TAG_W +: TAG_W];
              end
            end
            `HPE_ST_SEND: begin
              if (issue && rd_word[DATA_W]) begin
                state_reg <= `HPE_ST_IDLE;
              end
            end
            default: begin
              state_reg <= `HPE_ST_IDLE;
            end
          endcase
          rd_vld_reg <= issue;
          if (issue) begin
            rd_q_reg <= rd_word;
            rd_tag_reg <= tag_reg;
          end
          // two-word double buffer; the tag rides with its word so a
          // stalled last word keeps its own packet's tag after the next start
          if (pop && rd_vld_reg) begin
            if (st_cnt_reg == 2'd1) begin
              st0_reg <= rd_q_reg;
              st0_tag_reg <= rd_tag_reg;
            end else begin
              st0_reg <= st1_reg;
              st0_tag_reg <= st1_tag_reg;
              st1_reg <= rd_q_reg;
              st1_tag_reg <= rd_tag_reg;
            end
          end else if (pop) begin
            st0_reg <= st1_reg;
            st0_tag_reg <= st1_tag_reg;
            st_cnt_reg <= st_cnt_reg - 2'd1;
          end else if (rd_vld_reg) begin
            if (st_cnt_reg == 2'd0) begin
              st0_reg <= rd_q_reg;
              st0_tag_reg <= rd_tag_reg;
            end else begin
              st1_reg <= rd_q_reg;
              st1_tag_reg <= rd_tag_reg;
            end
            st_cnt_reg <= st_cnt_reg + 2'd1;
          end
        end
      end
    end
  endgenerate
endmodule

// file: verilog/hpe_fifo.v
// small valid/ready fifo in front of each packet buffer
`timescale 1ns/1ps
`include "hpe_consts.vh"
module hpe_fifo #(
  parameter WIDTH = 33,
  parameter DEPTH = `HPE_IN_FIFO_DEPTH,
  parameter AW = 4
) (
  // clock and reset
  input wire sys_clk,
  input wire rstn,
  // fill side
  input wire in_valid,
  input wire [WIDTH-1:0] in_data,
  output wire in_ready,
  // drain side
  output wire out_valid,
  output wire [WIDTH-1:0] out_data,
  input wire out_ready
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wr_ptr_reg;
  reg [AW-1:0] rd_ptr_reg;
  reg [AW:0] cnt_reg;
  wire push = in_valid & in_ready;
  wire pop = out_valid & out_ready;

  assign in_ready = (cnt_reg != DEPTH[AW:0]);
  assign out_valid = (cnt_reg != {(AW+1){1'b0}});
  assign out_data = mem[rd_ptr_reg];

  always @(posedge sys_clk) begin
    if (push) begin
      mem[wr_ptr_reg] <= in_data;
    end
  end

  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      wr_ptr_reg <= {AW{1'b0}};
      rd_ptr_reg <= {AW{1'b0}};
      cnt_reg <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_ptr_reg <= (wr_ptr_reg == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_reg <= (rd_ptr_reg == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr_reg + 1'b1;
      end
      if (push && !pop) begin
        cnt_reg <= cnt_reg + 1'b1;
      end else if (pop && !push) begin
        cnt_reg <= cnt_reg - 1'b1;
      end
    end
  end
endmodule
